// ### logic/bkp_backup_mem.sv
`timescale 1ns/10ps
`include "bkp_defines.svh"
module bkp_backup_mem import bkp_pkg::*; (
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire bkp_idx_t wr_addr,
	input wire bkp_word_t wr_data,
	input wire bkp_idx_t rd_addr,
	output bkp_word_t rd_data
);
	// no reset on purpose: contents must outlive a reset of the control logic
	bkp_word_t area [`BKP_DEPTH];

	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			area[wr_addr] <= wr_data;
		end
	end

	assign rd_data = area[rd_addr];

endmodule // bkp_backup_mem

// ### logic/bkp_defines.svh
`ifndef BKP_DEFINES_SVH
`define BKP_DEFINES_SVH

// register addresses, one 16-bit word each; upper half of a 32-bit value first
`define BKP_OFS_ACCESS_KEY_HI 16'h0040
`define BKP_OFS_ACCESS_KEY_LO 16'h0041
`define BKP_OFS_WRITE_KEY_HI 16'h0042
`define BKP_OFS_WRITE_KEY_LO 16'h0043
`define BKP_OFS_RESTORE_HI 16'h0196
`define BKP_OFS_RESTORE_LO 16'h0197
`define BKP_OFS_STORE_HI 16'h0198
`define BKP_OFS_STORE_LO 16'h0199

// industrial network command codes
`define BKP_CODE_RD_ACCESS_KEY 16'h0020
`define BKP_CODE_RD_WRITE_KEY 16'h0021
`define BKP_CODE_WR_ACCESS_KEY 16'h1020
`define BKP_CODE_WR_WRITE_KEY 16'h1021
`define BKP_CODE_RESTORE 16'h30cb
`define BKP_CODE_STORE 16'h30cc

// unlock values and reset values
`define BKP_ACCESS_UNLOCK 32'h01391955
`define BKP_WRITE_UNLOCK 32'h75db9c97
`define BKP_KEY_RESET 32'h00000000

// backup area geometry
`define BKP_DEPTH 16
`define BKP_IDX_W 4
`define BKP_LAST_IDX 4'hf
`define BKP_DATA_W 16

`endif

// ### logic/bkp_key_protect.sv
`timescale 1ns/10ps
`include "bkp_defines.svh"
// Function
// - readable, writable 32-bit access key register as two 16-bit words at 0040h/0041h.
// - readable, writable 32-bit write key register at the next pair, 0042h/0043h.
// - restore command reloads all backup words into working data; also network code 30CBh.
// - store command copies all working data into backup area; also network code 30CCh.
// - store needs access key 01391955h and write key 75DB9C97h.
// - restore needs only access key 01391955h; write key is ignored.
// - keys reset to zero; network reads and writes them by dedicated codes.
// - data stored in the backup area stays retrievable by a later restore.
module bkp_key_protect import bkp_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic reg_req,
	input wire bkp_reg_req_s reg_cmd,
	output logic reg_ack,
	output logic reg_err,
	output logic [15:0] reg_rdata,
	input wire logic net_req,
	input wire bkp_net_req_s net_cmd,
	output logic net_ack,
	output logic net_err,
	output logic [31:0] net_rdata,
	output bkp_idx_t work_addr,
	output logic work_re,
	output logic work_we,
	output bkp_word_t work_wdata,
	input wire bkp_word_t work_rdata,
	output logic busy,
	output logic done
);

	function automatic logic key_is(input logic [31:0] key, input logic [31:0] value);
		key_is = (key == value);
	endfunction

	function automatic logic [31:0] put_half(input logic [31:0] old, input logic upper, input logic [15:0] w);
		put_half = upper ? {w, old[15:0]} : {old[31:16], w};
	endfunction

	logic [31:0] key_access;
	logic [31:0] key_write;
	logic [31:0] next_key_access;
	logic [31:0] next_key_write;
	bkp_state_e state;
	bkp_state_e next_state;
	bkp_idx_t idx;
	bkp_idx_t next_idx;
	bkp_word_t bk_rdata;

	// register port decode
	wire reg_wr = reg_req & reg_cmd.we;
	wire a_acc_hi = reg_cmd.addr == `BKP_OFS_ACCESS_KEY_HI;
	wire a_acc_lo = reg_cmd.addr == `BKP_OFS_ACCESS_KEY_LO;
	wire a_wr_hi = reg_cmd.addr == `BKP_OFS_WRITE_KEY_HI;
	wire a_wr_lo = reg_cmd.addr == `BKP_OFS_WRITE_KEY_LO;
	wire a_rs_hi = reg_cmd.addr == `BKP_OFS_RESTORE_HI;
	wire a_rs_lo = reg_cmd.addr == `BKP_OFS_RESTORE_LO;
	wire a_st_hi = reg_cmd.addr == `BKP_OFS_STORE_HI;
	wire a_st_lo = reg_cmd.addr == `BKP_OFS_STORE_LO;
	wire a_key = a_acc_hi | a_acc_lo | a_wr_hi | a_wr_lo;
	wire a_cmd = a_rs_hi | a_rs_lo | a_st_hi | a_st_lo;
	wire reg_unmapped = ~(a_key | a_cmd);

	// writing the lower word of a command register fires it; the upper word is a no-op
	wire reg_restore = reg_wr & a_rs_lo;
	wire reg_store = reg_wr & a_st_lo;
	wire reg_cmd_any = reg_restore | reg_store;

	// network port decode
	// a network key write carries all 32 bits at once, so it needs no half-word pairing
	wire c_rd_acc = net_cmd.code == `BKP_CODE_RD_ACCESS_KEY;
	wire c_rd_wr = net_cmd.code == `BKP_CODE_RD_WRITE_KEY;
	wire c_wr_acc = net_cmd.code == `BKP_CODE_WR_ACCESS_KEY;
	wire c_wr_wr = net_cmd.code == `BKP_CODE_WR_WRITE_KEY;
	wire c_restore = net_cmd.code == `BKP_CODE_RESTORE;
	wire c_store = net_cmd.code == `BKP_CODE_STORE;
	wire net_unknown = ~(c_rd_acc | c_rd_wr | c_wr_acc | c_wr_wr | c_restore | c_store);
	wire net_restore = net_req & c_restore;
	wire net_store = net_req & c_store;
	wire net_cmd_any = net_restore | net_store;

	// key checks
	// the idle term refuses a command during a copy rather than restarting it halfway
	wire idle = state == BKP_IDLE;
	wire store_ok = idle & key_is(key_access, `BKP_ACCESS_UNLOCK) & key_is(key_write, `BKP_WRITE_UNLOCK);
	wire restore_ok = idle & key_is(key_access, `BKP_ACCESS_UNLOCK);

	// register port has priority when both ports fire a command in one cycle
	wire reg_go = (reg_store & store_ok) | (reg_restore & restore_ok);
	wire net_go = ~reg_cmd_any & ((net_store & store_ok) | (net_restore & restore_ok));
	wire start_store = (reg_store & store_ok) | (~reg_cmd_any & net_store & store_ok);
	wire start_restore = ~start_store & ((reg_restore & restore_ok) | (~reg_cmd_any & net_restore & restore_ok));

	// refused commands only raise an error; nothing is copied
	wire next_reg_err = reg_req & (reg_unmapped | (reg_cmd_any & ~reg_go));
	wire next_net_err = net_req & (net_unknown | (net_cmd_any & ~net_go));

	// read data; command registers are write-only and read as zero
	wire [15:0] next_reg_rdata = a_acc_hi ? key_access[31:16] :
		a_acc_lo ? key_access[15:0] :
		a_wr_hi ? key_write[31:16] :
		a_wr_lo ? key_write[15:0] : 16'h0000;
	wire [31:0] next_net_rdata = c_rd_acc ? key_access : c_rd_wr ? key_write : 32'h00000000;

	// commands never clear the keys; the host writes zero to lock the area again
	// key updates; register port wins a same-cycle clash with the network
	always_comb begin
		next_key_access = key_access;
		next_key_write = key_write;
		if (net_req && c_wr_acc) begin
			next_key_access = net_cmd.wdata;
		end
		if (net_req && c_wr_wr) begin
			next_key_write = net_cmd.wdata;
		end
		if (reg_wr && (a_acc_hi || a_acc_lo)) begin
			next_key_access = put_half(key_access, a_acc_hi, reg_cmd.wdata);
		end
		if (reg_wr && (a_wr_hi || a_wr_lo)) begin
			next_key_write = put_half(key_write, a_wr_hi, reg_cmd.wdata);
		end
	end

	// copy sequencer: one word per enabled cycle
	// idle parks idx at zero so every copy begins with word 0
	always_comb begin
		next_state = state;
		next_idx = idx;
		unique case (state)
			BKP_IDLE: begin
				next_idx = '0;
				if (start_store) begin
					next_state = BKP_STORE;
				end else if (start_restore) begin
					next_state = BKP_RESTORE;
				end
			end
			BKP_STORE, BKP_RESTORE: begin
				next_idx = bkp_idx_t'(idx + 1'b1);
				if (idx == `BKP_LAST_IDX) begin
					next_state = BKP_IDLE;
				end
			end
			default: begin
				next_state = BKP_IDLE;
				next_idx = '0;
			end
		endcase
	end

	// the backup write takes work_rdata in the same cycle the read address is shown, so the
	// working store must answer work_rdata combinationally from work_addr
	// depth is fixed at 16 words; a larger working set needs a deeper area and a wider idx
	bkp_backup_mem u_mem (
		.clk(clk),
		.ce(ce),
		.wr_en(work_re),
		.wr_addr(work_addr),
		.wr_data(work_rdata),
		.rd_addr(idx),
		.rd_data(bk_rdata)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			key_access <= `BKP_KEY_RESET;
			key_write <= `BKP_KEY_RESET;
			state <= BKP_IDLE;
			idx <= '0;
		end else if (ce) begin
			key_access <= next_key_access;
			key_write <= next_key_write;
			state <= next_state;
			idx <= next_idx;
		end
	end

	// a refused command still gets its ack, with err set, so the host never waits in vain
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_ack <= 1'b0;
			reg_err <= 1'b0;
			reg_rdata <= 16'h0000;
			net_ack <= 1'b0;
			net_err <= 1'b0;
			net_rdata <= 32'h00000000;
		end else if (ce) begin
			reg_ack <= reg_req;
			reg_err <= next_reg_err;
			reg_rdata <= reg_req ? next_reg_rdata : 16'h0000;
			net_ack <= net_req;
			net_err <= next_net_err;
			net_rdata <= net_req ? next_net_rdata : 32'h00000000;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			work_addr <= '0;
			work_re <= 1'b0;
			work_we <= 1'b0;
			work_wdata <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			work_addr <= idx;
			work_re <= state == BKP_STORE;
			work_we <= state == BKP_RESTORE;
			work_wdata <= bk_rdata;
			busy <= next_state != BKP_IDLE;
			done <= (state != BKP_IDLE) && (next_state == BKP_IDLE);
		end
	end

endmodule // bkp_key_protect

// ### logic/bkp_pkg.sv
`include "bkp_defines.svh"
package bkp_pkg;

	typedef logic [`BKP_IDX_W-1:0] bkp_idx_t;
	typedef logic [`BKP_DATA_W-1:0] bkp_word_t;

	// register port request: one 16-bit register access
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bkp_reg_req_s;

	// network port request: command code with 32-bit data
	typedef struct packed {
		logic [15:0] code;
		logic [31:0] wdata;
	} bkp_net_req_s;

	typedef enum logic [2:0] {
		BKP_IDLE = 3'b001,
		BKP_STORE = 3'b010,
		BKP_RESTORE = 3'b100
	} bkp_state_e;

endpackage

// ### sim/bkp_key_protect_chk.sv
`timescale 1ns/10ps
module bkp_key_protect_chk import bkp_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic reg_req,
	input wire logic reg_ack,
	input wire logic reg_err,
	input wire logic [15:0] reg_rdata,
	input wire logic net_req,
	input wire logic net_ack,
	input wire logic net_err,
	input wire bkp_idx_t work_addr,
	input wire logic work_re,
	input wire logic work_we,
	input wire logic busy,
	input wire logic done
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_reg_ack_due: assert property (ce && reg_req |=> reg_ack) else $error("reg ack late");
	a_net_ack_due: assert property (ce && net_req |=> net_ack) else $error("net ack late");
	a_store_from_zero: assert property ($rose(work_re) |-> work_addr == 4'h0) else $error("store start");
	a_restore_from_zero: assert property ($rose(work_we) |-> work_addr == 4'h0) else $error("restore start");
	a_copy_steps: assert property (ce && work_re && work_addr != 4'hf
		|=> work_re && work_addr == $past(work_addr) + 4'h1) else $error("copy step");
	a_done_at_last: assert property (done |-> (work_re || work_we) && work_addr == 4'hf) else $error("done early");
	a_done_ends_busy: assert property (done |-> !busy) else $error("busy after done");
	a_refused_no_copy: assert property (reg_ack && reg_err && !(net_ack && !net_err) |-> !$rose(busy))
		else $error("refused copy ran");
	a_rdata_idle_zero: assert property (!reg_ack |-> reg_rdata == 16'h0000) else $error("rdata idle");
endmodule // bkp_key_protect_chk

bind bkp_key_protect bkp_key_protect_chk i_bkp_key_protect_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
	.reg_req(reg_req), .reg_ack(reg_ack), .reg_err(reg_err), .reg_rdata(reg_rdata), .net_req(net_req),
	.net_ack(net_ack), .net_err(net_err), .work_addr(work_addr), .work_re(work_re), .work_we(work_we), .busy(busy),
	.done(done));

// ### sim/bkp_key_protect_test.sv
`timescale 1ns/10ps
module bkp_key_protect_test import bkp_pkg::*;;
	logic clk = 0, sys_rst = 1, ce = 1, reg_req = 0, net_req = 0;
	bkp_reg_req_s reg_cmd = '0;
	bkp_net_req_s net_cmd = '0;
	logic reg_ack, reg_err, net_ack, net_err, work_re, work_we, busy, done;
	logic [15:0] reg_rdata;
	logic [31:0] net_rdata;
	bkp_idx_t work_addr;
	bkp_word_t work_wdata, work_rdata;
	int err_total = 0, n_compared = 0;
	always #5 clk = ~clk;
	bkp_key_protect i_bkp_key_protect (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_req(reg_req),
		.reg_cmd(reg_cmd), .reg_ack(reg_ack), .reg_err(reg_err), .reg_rdata(reg_rdata), .net_req(net_req),
		.net_cmd(net_cmd), .net_ack(net_ack), .net_err(net_err), .net_rdata(net_rdata), .work_addr(work_addr),
		.work_re(work_re), .work_we(work_we), .work_wdata(work_wdata), .work_rdata(work_rdata), .busy(busy),
		.done(done));
	bkp_work_model i_bkp_work_model (.clk(clk), .work_addr(work_addr), .work_re(work_re), .work_we(work_we),
		.work_wdata(work_wdata), .work_rdata(work_rdata));
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic reg_acc(input logic we, input logic [15:0] a, input logic [15:0] d, input logic e,
		input logic [15:0] r);
		@(negedge clk);
		reg_req = 1;
		reg_cmd = '{we, a, d};
		@(negedge clk);
		reg_req = 0;
		chk({reg_ack, reg_err, reg_rdata}, {1'b1, e, r});
	endtask
	task automatic net_acc(input logic [15:0] c, input logic [31:0] d, input logic e, input logic [31:0] r);
		@(negedge clk);
		net_req = 1;
		net_cmd = '{c, d};
		@(negedge clk);
		net_req = 0;
		chk({net_ack, net_err, net_rdata}, {1'b1, e, r});
	endtask
	task automatic wait_done;
		for (int n = 0; n < 40 && done !== 1'b1; n++) @(negedge clk);
		chk(done, 1);
		repeat (2) @(negedge clk);
	endtask
	// f selects the pattern or all zero; set writes, else compares
	task automatic mem_op(input logic f, input logic set);
		for (int i = 0; i < 16; i++) begin
			if (set) i_bkp_work_model.mem[i] = f ? 16'(i * 16'h1111 + 16'h0101) : 16'h0;
			else chk(i_bkp_work_model.mem[i], f ? 16'(i * 16'h1111 + 16'h0101) : 16'h0);
		end
	endtask
	task give_verdict;
		if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		err_total++;
		give_verdict;
	end
	initial begin
		mem_op(1, 1);
		repeat (8) @(negedge clk);
		sys_rst = 0;
		for (int a = 16'h40; a < 16'h44; a++) reg_acc(0, 16'(a), 0, 0, 0);
		reg_acc(1, 16'h0199, 0, 1, 0);
		reg_acc(1, 16'h0040, 16'h0139, 0, 0);
		reg_acc(1, 16'h0041, 16'h1955, 0, 0);
		reg_acc(0, 16'h0040, 0, 0, 16'h0139);
		reg_acc(0, 16'h0041, 0, 0, 16'h1955);
		net_acc(16'h0020, 0, 0, 32'h01391955);
		net_acc(16'h30cc, 0, 1, 0);
		net_acc(16'h1021, 32'h75db9c97, 0, 0);
		reg_acc(0, 16'h0042, 0, 0, 16'h75db);
		reg_acc(0, 16'h0043, 0, 0, 16'h9c97);
		reg_acc(1, 16'h0198, 0, 0, 0);
		chk(busy, 0);
		reg_acc(1, 16'h0199, 0, 0, 0);
		repeat (4) @(negedge clk);
		ce = 0;
		repeat (3) @(negedge clk);
		chk({busy, work_re, work_addr}, {1'b1, 1'b1, 4'h3});
		ce = 1;
		wait_done;
		mem_op(0, 1);
		net_acc(16'h1021, 0, 0, 0);
		reg_acc(1, 16'h0199, 0, 1, 0);
		net_acc(16'h1020, 0, 0, 0);
		reg_acc(1, 16'h0197, 0, 1, 0);
		repeat (20) @(negedge clk);
		mem_op(0, 0);
		net_acc(16'h1020, 32'h01391955, 0, 0);
		net_acc(16'h30cb, 0, 0, 0);
		net_acc(16'h30cb, 0, 1, 0);
		wait_done;
		mem_op(1, 0);
		reg_acc(0, 16'h0050, 0, 1, 0);
		net_acc(16'h0021, 0, 0, 0);
		sys_rst = 1;
		repeat (2) @(negedge clk);
		sys_rst = 0;
		net_acc(16'h0020, 0, 0, 0);
		mem_op(0, 1);
		net_acc(16'h1020, 32'h01391955, 0, 0);
		net_acc(16'h30cb, 0, 0, 0);
		wait_done;
		mem_op(1, 0);
		give_verdict;
	end
endmodule // bkp_key_protect_test

// ### sim/bkp_work_model.sv
`timescale 1ns/10ps
module bkp_work_model import bkp_pkg::*; (
	input wire logic clk,
	input wire bkp_idx_t work_addr,
	input wire logic work_re,
	input wire logic work_we,
	input wire bkp_word_t work_wdata,
	output bkp_word_t work_rdata
);
	bkp_word_t mem [16];
	// inverse when not read, so a stale word never passes as valid
	assign work_rdata = work_re ? mem[work_addr] : ~mem[work_addr];
	always @(posedge clk) begin
		if (work_we) begin
			mem[work_addr] <= work_wdata;
		end
	end
endmodule // bkp_work_model
